/* File: logic/spo_pin_sync.sv */
// Purpose: two-flop level synchroniser, one lane per bit
// Assumes: inputs are levels, not pulses
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module spo_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    ////////////////////////////////////////////////////////////////////////////////
    // one generate lane per bit so each input keeps its own pair
    for (genvar g = 0; g < WIDTH; g++) begin : g_lane
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meta[g] <= 1'b0;
                q_o[g]  <= 1'b0;
            end else if (ce_i) begin
                meta[g] <= d_i[g];
                q_o[g]  <= meta[g];
            end
        end
    end
endmodule // spo_pin_sync
`default_nettype wire

/* File: logic/spo_pkg.sv */
// Purpose: shared constants and types for the serial pin override block
// Assumes: 16-bit register data, word-spaced register offsets
// Notes:   pin control and serial configuration travel as packed structs
package spo_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map
    localparam int          ADDR_W             = 8;
    localparam int          DATA_W             = 16;
    localparam logic [7:0]  OFS_PIN_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_SERIAL_CFG     = 8'h04;

    // pin control field positions
    localparam int          BIT_BRK_DATA       = 0;
    localparam int          BIT_BRK_DIR        = 1;
    localparam int          BIT_CLK_DATA       = 2;
    localparam int          BIT_CLK_DIR        = 3;

    // serial configuration field positions
    localparam int          BIT_SYNC_MODE      = 0;
    localparam int          BIT_CKE_LO         = 1;
    localparam int          BIT_CKE_HI         = 2;
    localparam int          BIT_TX_EN          = 3;
    localparam int          BIT_CFG_ERR        = 4;
    localparam int          BIT_TXD_LEVEL      = 5;

    // reset values
    localparam logic [3:0]  RST_PIN_CTRL       = 4'h0;
    localparam logic [3:0]  RST_SERIAL_CFG     = 4'h0;
    localparam logic [15:0] RST_RD_DATA        = 16'h0000;

    // cycles through a two-flop synchroniser
    localparam int          SYNC_STAGES        = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic clock_port_direction;
        logic clock_port_data;
        logic break_port_direction;
        logic break_port_data;
    } spo_pin_ctrl_type;

    typedef struct packed {
        logic transmit_enable;
        logic clock_enable_hi;
        logic clock_enable_lo;
        logic sync_mode;
    } spo_serial_cfg_type;

    // function of the clock pin
    typedef enum logic [4:0] {
        SCK_INPUT      = 5'b00001,
        SCK_PORT_OUT   = 5'b00010,
        SCK_INTERNAL   = 5'b00100,
        SCK_EXTERNAL   = 5'b01000,
        SCK_PROHIBITED = 5'b10000
    } spo_sck_mode_type;

endpackage

/* File: logic/spo_top.sv */
// Purpose: override logic for a serial channel's clock, transmit and receive pins
// Assumes: serial core drives its clock and transmit data on link_clk_i
// Notes:   pin levels are resynchronised before any logic or readback sees them
//
// Operation
// - async, no clock enables: clock pin input, or drives clock data when direction set
// - internal clock drives clock pin in async lo-enable or sync hi-clear modes
// - hi-enable set, lo clear: clock pin is external clock input; both set prohibited
// - transmitter off: transmit pin input, or drives break data when direction set
// - transmitter on: transmit pin carries core transmit data
// - reading break data returns receive pin level, not stored value
// - break direction resets to 0; data bits store 0, read undefined
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module spo_top
    import spo_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input  wire logic          core_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          ce_i,
    // register port
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [DW-1:0] rd_data_o,
    // serial core, link clock side
    input  wire logic          link_clk_i,
    input  wire logic          core_sck_i,
    input  wire logic          core_txd_i,
    output logic               link_rxd_o,
    // serial core, bus clock side
    output logic               ext_clk_o,
    // pins
    input  wire logic          sck_i,
    output logic               sck_o,
    output logic               sck_oe_o,
    input  wire logic          txd_i,
    output logic               txd_o,
    output logic               txd_oe_o,
    input  wire logic          rxd_i
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode of the clock pin function, shared by pin logic and status
    function automatic spo_sck_mode_type sck_mode(input spo_serial_cfg_type c,
                                                  input logic dir);
        unique case ({c.sync_mode, c.clock_enable_hi, c.clock_enable_lo})
            3'b000:  sck_mode = dir ? SCK_PORT_OUT : SCK_INPUT;
            3'b001:  sck_mode = SCK_INTERNAL;
            3'b010:  sck_mode = SCK_EXTERNAL;
            3'b011:  sck_mode = SCK_PROHIBITED;
            3'b100:  sck_mode = SCK_INTERNAL;
            3'b101:  sck_mode = SCK_INTERNAL;
            3'b110:  sck_mode = SCK_EXTERNAL;
            3'b111:  sck_mode = SCK_PROHIBITED;
        endcase
    endfunction

    logic               rst_meta;
    logic               rst_n;
    logic               link_rst_meta;
    logic               link_rst_n;
    logic               link_sck;
    logic               link_txd;
    spo_pin_ctrl_type   pin_ctrl;
    spo_serial_cfg_type serial_cfg;
    logic               sck_sync;
    logic               rxd_sync;
    logic               txd_sync;
    logic               core_sck_sync;
    logic               core_txd_sync;
    spo_sck_mode_type   mode;
    logic               next_sck_o;
    logic               next_sck_oe;
    logic               next_txd_o;
    logic               next_txd_oe;
    logic [DW-1:0]      next_rd_data;

    ////////////////////////////////////////////////////////////////////////////////
    // reset release through two flops, one copy per domain
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_rst_meta <= 1'b0;
            link_rst_n    <= 1'b0;
        end else begin
            link_rst_meta <= 1'b1;
            link_rst_n    <= link_rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: capture core clock and data so they leave as clean levels
    always_ff @(posedge link_clk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_sck <= 1'b0;
            link_txd <= 1'b1;
        end else begin
            link_sck <= core_sck_i;
            link_txd <= core_txd_i;
        end
    end

    // receive level into the core's own domain
    spo_pin_sync #(
        .WIDTH(1)
    ) u_link_sync (
        .clk_i   (link_clk_i),
        .rst_n_i (link_rst_n),
        .ce_i    (1'b1),
        .d_i     (rxd_i),
        .q_o     (link_rxd_o)
    );

    // pins and link levels into the bus domain
    spo_pin_sync #(
        .WIDTH(5)
    ) u_core_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .d_i     ({sck_i, rxd_i, txd_i, link_sck, link_txd}),
        .q_o     ({sck_sync, rxd_sync, txd_sync, core_sck_sync, core_txd_sync})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register writes; stored data bits reset to 0
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_ctrl <= RST_PIN_CTRL;
        end else if (ce_i && wr_i && addr_i == AW'(OFS_PIN_CTRL)) begin
            pin_ctrl.clock_port_direction <= wr_data_i[BIT_CLK_DIR];
            pin_ctrl.clock_port_data      <= wr_data_i[BIT_CLK_DATA];
            pin_ctrl.break_port_direction <= wr_data_i[BIT_BRK_DIR];
            pin_ctrl.break_port_data      <= wr_data_i[BIT_BRK_DATA];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_cfg <= RST_SERIAL_CFG;
        end else if (ce_i && wr_i && addr_i == AW'(OFS_SERIAL_CFG)) begin
            serial_cfg.sync_mode       <= wr_data_i[BIT_SYNC_MODE];
            serial_cfg.clock_enable_lo <= wr_data_i[BIT_CKE_LO];
            serial_cfg.clock_enable_hi <= wr_data_i[BIT_CKE_HI];
            serial_cfg.transmit_enable <= wr_data_i[BIT_TX_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin steering; a prohibited enable pair leaves the pin undriven, safest choice
    always_comb begin
        mode        = sck_mode(serial_cfg, pin_ctrl.clock_port_direction);
        next_sck_o  = 1'b0;
        next_sck_oe = 1'b0;
        unique case (mode)
            SCK_INPUT:      next_sck_oe = 1'b0;
            SCK_PORT_OUT: begin
                next_sck_oe = 1'b1;
                next_sck_o  = pin_ctrl.clock_port_data;
            end
            SCK_INTERNAL: begin
                next_sck_oe = 1'b1;
                next_sck_o  = core_sck_sync;
            end
            SCK_EXTERNAL:   next_sck_oe = 1'b0;
            SCK_PROHIBITED: next_sck_oe = 1'b0;
        endcase
        if (serial_cfg.transmit_enable) begin
            next_txd_oe = 1'b1;
            next_txd_o  = core_txd_sync;
        end else begin
            next_txd_oe = pin_ctrl.break_port_direction;
            next_txd_o  = pin_ctrl.break_port_data;
        end
    end

    // pins follow one edge after the register; break output held high only in reset
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sck_o    <= 1'b0;
            sck_oe_o <= 1'b0;
            txd_o    <= 1'b1;
            txd_oe_o <= 1'b0;
        end else if (ce_i) begin
            sck_o    <= next_sck_o;
            sck_oe_o <= next_sck_oe;
            txd_o    <= next_txd_o;
            txd_oe_o <= next_txd_oe;
        end
    end

    // external clock only reaches the core when that function is selected
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_clk_o <= 1'b0;
        end else if (ce_i) begin
            ext_clk_o <= (mode == SCK_EXTERNAL) ? sck_sync : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // readback: data bits show pin levels, not the stored setting
    always_comb begin
        next_rd_data = DW'(RST_RD_DATA);
        if (addr_i == AW'(OFS_PIN_CTRL)) begin
            next_rd_data[BIT_CLK_DIR]  = pin_ctrl.clock_port_direction;
            next_rd_data[BIT_CLK_DATA] = sck_sync;
            next_rd_data[BIT_BRK_DIR]  = pin_ctrl.break_port_direction;
            next_rd_data[BIT_BRK_DATA] = rxd_sync;
        end else if (addr_i == AW'(OFS_SERIAL_CFG)) begin
            next_rd_data[BIT_SYNC_MODE] = serial_cfg.sync_mode;
            next_rd_data[BIT_CKE_LO]    = serial_cfg.clock_enable_lo;
            next_rd_data[BIT_CKE_HI]    = serial_cfg.clock_enable_hi;
            next_rd_data[BIT_TX_EN]     = serial_cfg.transmit_enable;
            next_rd_data[BIT_CFG_ERR]   = (mode == SCK_PROHIBITED);
            next_rd_data[BIT_TXD_LEVEL] = txd_sync;
        end
    end

    // data stands for exactly the cycle after the strobe
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_o <= DW'(RST_RD_DATA);
        end else if (ce_i) begin
            rd_data_o <= rd_i ? next_rd_data : DW'(RST_RD_DATA);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks, bus clock domain
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    property p_sck_port;
        (ce_i && !serial_cfg.sync_mode && !serial_cfg.clock_enable_hi
         && !serial_cfg.clock_enable_lo)
        |=> (sck_oe_o == $past(pin_ctrl.clock_port_direction))
            && (!sck_oe_o || sck_o == $past(pin_ctrl.clock_port_data));
    endproperty
    a_sck_port: assert property (p_sck_port)
        else $error("clock pin port mode wrong");

    property p_sck_internal;
        (ce_i && ((!serial_cfg.sync_mode && !serial_cfg.clock_enable_hi
                   && serial_cfg.clock_enable_lo)
                  || (serial_cfg.sync_mode && !serial_cfg.clock_enable_hi)))
        |=> sck_oe_o && (sck_o == $past(core_sck_sync));
    endproperty
    a_sck_internal: assert property (p_sck_internal)
        else $error("internal clock not on clock pin");

    property p_sck_external;
        (ce_i && serial_cfg.clock_enable_hi && !serial_cfg.clock_enable_lo)
        |=> !sck_oe_o && (ext_clk_o == $past(sck_sync));
    endproperty
    a_sck_external: assert property (p_sck_external)
        else $error("external clock mode drives pin");

    property p_txd_port;
        (ce_i && !serial_cfg.transmit_enable)
        |=> (txd_oe_o == $past(pin_ctrl.break_port_direction))
            && (!txd_oe_o || txd_o == $past(pin_ctrl.break_port_data));
    endproperty
    a_txd_port: assert property (p_txd_port)
        else $error("transmit pin port mode wrong");

    property p_txd_core;
        (ce_i && serial_cfg.transmit_enable) |=> txd_oe_o && (txd_o == $past(core_txd_sync));
    endproperty
    a_txd_core: assert property (p_txd_core)
        else $error("transmit data not on pin");

    property p_rxd_read;
        (ce_i && rd_i && addr_i == AW'(OFS_PIN_CTRL))
        |=> rd_data_o[BIT_BRK_DATA] == $past(rxd_sync);
    endproperty
    a_rxd_read: assert property (p_rxd_read)
        else $error("break data read not pin level");

    property p_reset_state;
        $rose(rst_n) |-> !pin_ctrl.break_port_direction && !txd_oe_o && !sck_oe_o;
    endproperty
    a_reset_state: assert property (@(posedge core_clk_i) p_reset_state)
        else $error("state after reset wrong");

    sequence s_brk_drive_write;
        ce_i && wr_i && addr_i == AW'(OFS_PIN_CTRL) && wr_data_i[BIT_BRK_DIR]
        && !serial_cfg.transmit_enable;
    endsequence
    sequence s_brk_drive_apply;
        ce_i && !serial_cfg.transmit_enable ##1 txd_oe_o;
    endsequence
    property p_write_to_pin;
        s_brk_drive_write |=> s_brk_drive_apply;
    endproperty
    a_write_to_pin: assert property (p_write_to_pin)
        else $error("write did not reach pin next edge");

    property p_read_only_once;
        (ce_i && !rd_i) |=> rd_data_o == RST_RD_DATA;
    endproperty
    a_read_only_once: assert property (p_read_only_once)
        else $error("read data outside its cycle");

endmodule // spo_top
`default_nettype wire

/* File: test/spo_serial_dev.sv */
// Purpose: far-side serial device on the channel's clock, transmit and receive pins
// Assumes: the device always drives the pins it owns; the block wins where its enable is high
// Notes:   levels chosen by the bench through the dev_*_i controls
`timescale 1ns/1ps
`default_nettype none
module spo_serial_dev (
    input  wire logic sck_o_i,
    input  wire logic sck_oe_i,
    input  wire logic txd_o_i,
    input  wire logic txd_oe_i,
    input  wire logic dev_sck_i,
    input  wire logic dev_txd_i,
    input  wire logic dev_rxd_i,
    output logic      sck_pin_o,
    output logic      txd_pin_o,
    output logic      rxd_pin_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // wire resolution: block's driver overrides the device's weak level
    assign sck_pin_o = sck_oe_i ? sck_o_i : dev_sck_i;
    assign txd_pin_o = txd_oe_i ? txd_o_i : dev_txd_i;
    // receive line belongs to the device alone
    assign rxd_pin_o = dev_rxd_i;
endmodule // spo_serial_dev
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the serial pin override block
// Assumes: register port with one-cycle strobes, read data in the following cycle
// Notes:   pin paths pass synchronisers, so most pin checks wait a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import spo_pkg::*;
    logic        core_clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic        ce       = 1'b1;
    logic [7:0]  addr     = 8'h00;
    logic [15:0] wdata    = 16'h0000;
    logic [15:0] rdata;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic        core_sck = 1'b0;
    logic        core_txd = 1'b1;
    logic        dev_sck  = 1'b0;
    logic        dev_txd  = 1'b1;
    logic        dev_rxd  = 1'b1;
    logic        link_rxd, ext_clk, sck_pin, sck_o, sck_oe, txd_pin, txd_o, txd_oe, rxd_pin;
    int          failures    = 0;
    int          check_count = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clocks: 32 ns link clock offset by 3 ns against the 10 ns bus clock; edges still coincide at times, both rise at 115 ns
    always #5 core_clk = ~core_clk;
    always begin
        #3;
        forever #16 link_clk = ~link_clk;
    end

    spo_top dut_u (.core_clk_i(core_clk), .nrst_i(nrst), .ce_i(ce), .addr_i(addr),
        .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .link_clk_i(link_clk),
        .core_sck_i(core_sck), .core_txd_i(core_txd), .link_rxd_o(link_rxd),
        .ext_clk_o(ext_clk), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe),
        .txd_i(txd_pin), .txd_o(txd_o), .txd_oe_o(txd_oe), .rxd_i(rxd_pin));

    spo_serial_dev dev_u (.sck_o_i(sck_o), .sck_oe_i(sck_oe), .txd_o_i(txd_o),
        .txd_oe_i(txd_oe), .dev_sck_i(dev_sck), .dev_txd_i(dev_txd), .dev_rxd_i(dev_rxd),
        .sck_pin_o(sck_pin), .txd_pin_o(txd_pin), .rxd_pin_o(rxd_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    // data sampled only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // long enough for link flop, two sync flops and the output flop
    task automatic settle();
        @(posedge link_clk);
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog: the tests need a few microseconds
    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tests; pins taken as already handed to the serial function
    initial begin
        logic [15:0] v;
        logic        d;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        check(sck_oe, 1'b0);
        check(txd_oe, 1'b0);
        reg_rd(OFS_PIN_CTRL, v);
        check(v, 16'h0001);
        @(posedge core_clk);
        #1 check(rdata, 16'h0000);
        reg_rd(OFS_SERIAL_CFG, v);
        check(v, 16'h0020);
        $display("test reset done");

        // clock pin as port: direction 1 drives data, next edge after the write
        for (int i = 0; i < 2; i++) begin
            d = i[0];
            reg_wr(OFS_PIN_CTRL, {12'h000, 1'b1, d, 2'b00});
            @(posedge core_clk);
            #1 check(sck_oe, 1'b1);
            check(sck_o, d);
            settle();
            reg_rd(OFS_PIN_CTRL, v);
            check(v[2], d);
        end
        // far side sits opposite the last driven level, so a stale pin would show up
        @(posedge core_clk);
        dev_sck <= 1'b0;
        reg_wr(OFS_PIN_CTRL, 16'h0000);
        settle();
        check(sck_oe, 1'b0);
        reg_rd(OFS_PIN_CTRL, v);
        check(v[2], 1'b0);
        $display("test clock port done");

        // transmit pin as port; readback shows the receive line, not the stored bit
        @(posedge core_clk);
        dev_rxd <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            d = ~i[0];
            reg_wr(OFS_PIN_CTRL, {14'h0000, 1'b1, d});
            @(posedge core_clk);
            #1 check(txd_oe, 1'b1);
            check(txd_o, d);
            settle();
            reg_rd(OFS_PIN_CTRL, v);
            check(v[1:0], 2'b10);
        end
        reg_wr(OFS_PIN_CTRL, 16'h0001);
        settle();
        check(txd_oe, 1'b0);
        // last drive was low; released pin must show the far side's idle high
        reg_rd(OFS_SERIAL_CFG, v);
        check(v[5], 1'b1);
        $display("test break port done");

        // internal clock modes: port bits set to drive low, yet the core clock wins
        reg_wr(OFS_PIN_CTRL, 16'h0008);
        foreach (v[k]) begin
            if (k > 2) continue;
            reg_wr(OFS_SERIAL_CFG, (k == 0) ? 16'h0002 : (k == 1) ? 16'h0001 : 16'h0003);
            for (int j = 1; j >= 0; j--) begin
                @(posedge link_clk);
                core_sck <= j[0];
                settle();
                check(sck_oe, 1'b1);
                check(sck_o, j[0]);
            end
        end
        $display("test internal clock done");

        // external clock in both modes, then the prohibited pair
        for (int m = 4; m < 8; m++) begin
            reg_wr(OFS_SERIAL_CFG, 16'(m));
            for (int j = 1; j >= 0; j--) begin
                @(posedge core_clk);
                dev_sck <= j[0];
                settle();
                check(sck_oe, 1'b0);
                check(ext_clk, (m < 6) ? j[0] : 1'b0);
            end
            reg_rd(OFS_SERIAL_CFG, v);
            check(v[4], (m >= 6) ? 1'b1 : 1'b0);
        end
        $display("test external clock done");

        // transmitter on: core data reaches the pin despite break port low
        reg_wr(OFS_PIN_CTRL, 16'h0002);
        reg_wr(OFS_SERIAL_CFG, 16'h0008);
        for (int j = 0; j < 2; j++) begin
            @(posedge link_clk);
            core_txd <= j[0];
            settle();
            check(txd_oe, 1'b1);
            check(txd_o, j[0]);
            reg_rd(OFS_SERIAL_CFG, v);
            check(v[5], j[0]);
        end
        @(posedge core_clk);
        dev_rxd <= 1'b1;
        settle();
        check(link_rxd, 1'b1);
        $display("test transmit done");

        // unmapped read, then a write while the clock enable is low
        reg_rd(8'h10, v);
        check(v, 16'h0000);
        @(posedge core_clk);
        ce <= 1'b0;
        reg_wr(OFS_PIN_CTRL, 16'h0008);
        ce <= 1'b1;
        reg_rd(OFS_PIN_CTRL, v);
        check(v[3:1], 3'b001);
        $display("test odd access done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
